// File: src/fcc_pkg.sv
// Package for the fieldbus slave configuration checker
package fcc_pkg;
  // Register byte offsets
  localparam logic [7:0] OFF_MAP_CNT = 8'h00;
  localparam logic [7:0] OFF_OUT_CH = 8'h04;
  localparam logic [7:0] OFF_OUT_ADDR = 8'h08;
  localparam logic [7:0] OFF_IN_CH = 8'h0c;
  localparam logic [7:0] OFF_IN_ADDR = 8'h10;
  localparam logic [7:0] OFF_MBX = 8'h14;
  localparam logic [7:0] OFF_PDO_LEN = 8'h18;
  localparam logic [7:0] OFF_WIN = 8'h1c;
  localparam logic [7:0] OFF_MISC = 8'h20;
  localparam logic [7:0] OFF_CHECK = 8'h24;
  localparam logic [7:0] OFF_FAULT = 8'h28;
  localparam logic [7:0] OFF_CODE = 8'h2c;
  localparam logic [7:0] OFF_MAP_IDX = 8'h30;

  localparam logic [4:0] MAX_MAP = 5'h0a;
  localparam logic [15:0] RX_IDX_LO = 16'h1600;
  localparam logic [15:0] RX_IDX_HI = 16'h170a;
  localparam logic [15:0] TX_IDX_LO = 16'h1a00;
  localparam logic [15:0] TX_IDX_HI = 16'h1b0a;

  // Fault bit positions
  localparam int F_MAP = 0;
  localparam int F_MBX = 1;
  localparam int F_OUT = 2;
  localparam int F_IN = 3;
  localparam int F_WDG = 4;
  localparam int F_SYNC = 5;
  localparam int F_ESI = 6;
  localparam int F_EEP = 7;
  localparam int F_MODEL = 8;
  localparam int NFAULT = 9;

  // Display codes, major in [15:8], minor in [3:0]
  localparam logic [15:0] C_NONE = 16'h0000;
  localparam logic [15:0] C_MAP = 16'h0905;
  localparam logic [15:0] C_MBX = 16'h1000;
  localparam logic [15:0] C_OUT = 16'h1001;
  localparam logic [15:0] C_IN = 16'h1002;
  localparam logic [15:0] C_WDG = 16'h1003;
  localparam logic [15:0] C_SYNC = 16'h1004;
  localparam logic [15:0] C_ESI = 16'h1100;
  localparam logic [15:0] C_EEP = 16'h1101;
  localparam logic [15:0] C_MODEL = 16'h1103;

  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

  typedef struct packed {
    logic en;
    logic dir_write;
    logic [13:0] len;
    logic [15:0] start;
  } fcc_chan_t;

  typedef struct packed {
    logic [15:0] lo;
    logic [15:0] hi;
  } fcc_win_t;
endpackage

// File: src/fcc_checker.sv
// Fieldbus slave configuration checker with AHB-Lite register slave
//
// Added by the designer: the AHB-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
// Operation
// (R1) Over ten mapped objects raises mapping fault
// (R2) Bad mailbox channel setup raises mailbox fault
// (R3) Receive mapping index out of range faults
// (R4) Disabled output channel needs zero lengths
// (R5) Receive length mismatch faults output channel
// (R6) Output channel in read direction faults
// (R7) Receive address window or start clash
// (R8) Output channel overlapping neighbours faults
// (R9) Transmit mapping index out of range faults
// (R10) Disabled input channel needs zero lengths
// (R11) Transmit length mismatch faults input channel
// (R12) Input channel in write direction faults
// (R13) Transmit address window or start clash
// (R14) Output memory overlapping others faults input
// (R15) Watchdog enable and count must agree
// (R16) Clocks enabled but not running faults
// (R17) Description image load failure faults
// (R18) Unreadable EEPROM communication data faults
// (R19) Description not matching model faults
// (R20) Active fault code shown on display
// (R21) Faults latched distinctly until cleared
module fcc_checker #(
  parameter int MAP_MAX = 10
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Status pins from EEPROM loader and sync unit
  input wire logic esi_load_fail,
  input wire logic eep_read_fail,
  input wire logic model_mismatch,
  input wire logic dc_running,
  // Operator display
  output logic [15:0] display_code
);

  // Configuration registers
  logic [9:0] map_cnt_ff;
  fcc_pkg::fcc_chan_t out_ch_ff, in_ch_ff, mbx_out_ff, mbx_in_ff;
  logic [15:0] rx_len_ff, tx_len_ff;
  fcc_pkg::fcc_win_t rx_win_ff, tx_win_ff;
  logic [15:0] rx_addr_ff, tx_addr_ff;
  logic [31:0] map_idx_ff;
  logic [15:0] wdg_cnt_ff;
  logic wdg_en_ff, dc_en_ff, preop_ff, sync_chk_ff, expect_ok_ff;
  logic [15:0] exp_rx_len_ff, exp_tx_len_ff;
  logic [fcc_pkg::NFAULT-1:0] fault_ff, det;
  logic [15:0] nxt_display_code;
  logic s1_ff, s2_ff, e1_ff, e2_ff, m1_ff, m2_ff, d1_ff, d2_ff;

  // Bus phase capture
  logic wr_ff, rd_ff;
  logic [7:0] addr_ff;
  logic chk_pulse;

  function automatic logic ovl(input fcc_pkg::fcc_chan_t a, input fcc_pkg::fcc_chan_t b);
    logic [16:0] ae, be;
    ae = {1'b0, a.start} + {3'b000, a.len};
    be = {1'b0, b.start} + {3'b000, b.len};
    ovl = a.en && b.en && ({1'b0, a.start} < be) && ({1'b0, b.start} < ae);
  endfunction

  function automatic logic outside(input logic [15:0] v, input logic [15:0] lo,
                                   input logic [15:0] hi);
    outside = (v < lo) || (v > hi);
  endfunction

  // Pin synchronisers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      {s1_ff, s2_ff, e1_ff, e2_ff} <= 4'h0;
      {m1_ff, m2_ff, d1_ff, d2_ff} <= 4'h0;
    end else begin
      s1_ff <= esi_load_fail;
      s2_ff <= s1_ff;
      e1_ff <= eep_read_fail;
      e2_ff <= e1_ff;
      m1_ff <= model_mismatch;
      m2_ff <= m1_ff;
      d1_ff <= dc_running;
      d2_ff <= d1_ff;
    end
  end

  // Address phase capture; zero wait states
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_ff <= 1'b0;
      rd_ff <= 1'b0;
      addr_ff <= 8'h00;
    end else if (hready) begin
      wr_ff <= hsel && htrans == fcc_pkg::HTRANS_NONSEQ && hwrite;
      rd_ff <= hsel && htrans == fcc_pkg::HTRANS_NONSEQ && !hwrite;
      addr_ff <= haddr[7:0];
    end else begin
      wr_ff <= 1'b0;
      rd_ff <= 1'b0;
    end
  end

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign chk_pulse = wr_ff && addr_ff == fcc_pkg::OFF_CHECK && hwdata[0];

  // Register writes
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      map_cnt_ff <= 10'h000;
      out_ch_ff <= '0;
      in_ch_ff <= '0;
      mbx_out_ff <= '0;
      mbx_in_ff <= '0;
      rx_len_ff <= 16'h0000;
      tx_len_ff <= 16'h0000;
      rx_win_ff <= '0;
      tx_win_ff <= '0;
      rx_addr_ff <= 16'h0000;
      tx_addr_ff <= 16'h0000;
      map_idx_ff <= 32'h0000_0000;
      wdg_cnt_ff <= 16'h0000;
      wdg_en_ff <= 1'b0;
      dc_en_ff <= 1'b0;
      preop_ff <= 1'b0;
      sync_chk_ff <= 1'b0;
      exp_rx_len_ff <= 16'h0000;
      exp_tx_len_ff <= 16'h0000;
    end else if (wr_ff) begin
      unique case (addr_ff)
        fcc_pkg::OFF_MAP_CNT: map_cnt_ff <= hwdata[9:0];
        fcc_pkg::OFF_OUT_CH: out_ch_ff <= hwdata;
        fcc_pkg::OFF_OUT_ADDR: begin
          rx_addr_ff <= hwdata[15:0];
          exp_rx_len_ff <= hwdata[31:16];
        end
        fcc_pkg::OFF_IN_CH: in_ch_ff <= hwdata;
        fcc_pkg::OFF_IN_ADDR: begin
          tx_addr_ff <= hwdata[15:0];
          exp_tx_len_ff <= hwdata[31:16];
        end
        fcc_pkg::OFF_MBX: begin
          mbx_out_ff <= {2'b10, hwdata[13:0], hwdata[31:16]};
          mbx_in_ff <= {2'b10, hwdata[13:0], hwdata[31:16] + {2'b00, hwdata[13:0]}};
        end
        fcc_pkg::OFF_PDO_LEN: begin
          rx_len_ff <= hwdata[15:0];
          tx_len_ff <= hwdata[31:16];
        end
        fcc_pkg::OFF_WIN: begin
          rx_win_ff <= hwdata;
          tx_win_ff <= hwdata;
        end
        fcc_pkg::OFF_MISC: begin
          wdg_cnt_ff <= hwdata[15:0];
          wdg_en_ff <= hwdata[16];
          dc_en_ff <= hwdata[17];
          preop_ff <= hwdata[18];
          sync_chk_ff <= hwdata[19];
        end
        fcc_pkg::OFF_MAP_IDX: map_idx_ff <= hwdata;
        default: ;
      endcase
    end
  end

  // Checks, evaluated continuously
  always_comb begin
    det = '0;
    det[fcc_pkg::F_MAP] = map_cnt_ff[4:0] > MAP_MAX[4:0] ||
                          map_cnt_ff[9:5] > MAP_MAX[4:0] ||
                          map_cnt_ff[4:0] > fcc_pkg::MAX_MAP; // [R1]
    det[fcc_pkg::F_MBX] = mbx_out_ff.len == 14'h0000 ||
                          ovl(mbx_out_ff, mbx_in_ff) ||
                          mbx_out_ff.start + {2'b00, mbx_out_ff.len} !=
                          mbx_in_ff.start; // [R2]
    det[fcc_pkg::F_OUT] =
      (map_cnt_ff[4:0] != 5'h00 &&
       outside(map_idx_ff[15:0], fcc_pkg::RX_IDX_LO, fcc_pkg::RX_IDX_HI)) || // [R3]
      (!out_ch_ff.en && (out_ch_ff.len != 14'h0000 || rx_len_ff != 16'h0000)) || // [R4]
      (out_ch_ff.en && rx_len_ff != exp_rx_len_ff) || // [R5]
      (out_ch_ff.en && !out_ch_ff.dir_write) || // [R6]
      (out_ch_ff.en && (preop_ff ? outside(rx_addr_ff, rx_win_ff.lo, rx_win_ff.hi)
                                 : out_ch_ff.start == rx_addr_ff)) || // [R7]
      ovl(out_ch_ff, mbx_in_ff) || ovl(out_ch_ff, in_ch_ff); // [R8]
    det[fcc_pkg::F_IN] =
      (map_cnt_ff[9:5] != 5'h00 &&
       outside(map_idx_ff[31:16], fcc_pkg::TX_IDX_LO, fcc_pkg::TX_IDX_HI)) || // [R9]
      (!in_ch_ff.en && (in_ch_ff.len != 14'h0000 || tx_len_ff != 16'h0000)) || // [R10]
      (in_ch_ff.en && tx_len_ff != exp_tx_len_ff) || // [R11]
      (in_ch_ff.en && in_ch_ff.dir_write) || // [R12]
      (in_ch_ff.en && (preop_ff ? outside(tx_addr_ff, tx_win_ff.lo, tx_win_ff.hi)
                                : in_ch_ff.start == tx_addr_ff)) || // [R13]
      ovl(out_ch_ff, in_ch_ff) || ovl(out_ch_ff, mbx_out_ff) ||
      ovl(out_ch_ff, mbx_in_ff); // [R14]
    det[fcc_pkg::F_WDG] = (wdg_en_ff && wdg_cnt_ff == 16'h0000) ||
                          (!wdg_en_ff && wdg_cnt_ff != 16'h0000); // [R15]
    det[fcc_pkg::F_SYNC] = sync_chk_ff && dc_en_ff && !d2_ff; // [R16]
    det[fcc_pkg::F_ESI] = s2_ff; // [R17]
    det[fcc_pkg::F_EEP] = e2_ff; // [R18]
    det[fcc_pkg::F_MODEL] = m2_ff; // [R19]
  end

  // Sticky faults; a new detection wins over the clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fault_ff <= '0;
    end else begin
      logic [fcc_pkg::NFAULT-1:0] nxt_fault;
      nxt_fault = fault_ff;
      if (wr_ff && addr_ff == fcc_pkg::OFF_FAULT) begin
        nxt_fault = fault_ff & ~hwdata[fcc_pkg::NFAULT-1:0];
      end
      if (chk_pulse) begin
        nxt_fault = nxt_fault | (det & ~(9'h1e0));
      end
      fault_ff <= nxt_fault | (det & 9'h1e0); // [R21]
    end
  end

  // Lowest-numbered active fault drives the display
  always_comb begin
    nxt_display_code = fcc_pkg::C_NONE;
    if (fault_ff[fcc_pkg::F_MODEL]) nxt_display_code = fcc_pkg::C_MODEL;
    if (fault_ff[fcc_pkg::F_EEP]) nxt_display_code = fcc_pkg::C_EEP;
    if (fault_ff[fcc_pkg::F_ESI]) nxt_display_code = fcc_pkg::C_ESI;
    if (fault_ff[fcc_pkg::F_SYNC]) nxt_display_code = fcc_pkg::C_SYNC;
    if (fault_ff[fcc_pkg::F_WDG]) nxt_display_code = fcc_pkg::C_WDG;
    if (fault_ff[fcc_pkg::F_IN]) nxt_display_code = fcc_pkg::C_IN;
    if (fault_ff[fcc_pkg::F_OUT]) nxt_display_code = fcc_pkg::C_OUT;
    if (fault_ff[fcc_pkg::F_MBX]) nxt_display_code = fcc_pkg::C_MBX;
    if (fault_ff[fcc_pkg::F_MAP]) nxt_display_code = fcc_pkg::C_MAP;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      display_code <= fcc_pkg::C_NONE;
    end else begin
      display_code <= nxt_display_code; // [R20]
    end
  end

  // Read data
  always_comb begin
    unique case (addr_ff)
      fcc_pkg::OFF_MAP_CNT: hrdata = {22'h0, map_cnt_ff};
      fcc_pkg::OFF_OUT_CH: hrdata = out_ch_ff;
      fcc_pkg::OFF_OUT_ADDR: hrdata = {exp_rx_len_ff, rx_addr_ff};
      fcc_pkg::OFF_IN_CH: hrdata = in_ch_ff;
      fcc_pkg::OFF_IN_ADDR: hrdata = {exp_tx_len_ff, tx_addr_ff};
      fcc_pkg::OFF_MBX: hrdata = {mbx_out_ff.start, 2'h0, mbx_out_ff.len};
      fcc_pkg::OFF_PDO_LEN: hrdata = {tx_len_ff, rx_len_ff};
      fcc_pkg::OFF_WIN: hrdata = rx_win_ff;
      fcc_pkg::OFF_MISC: hrdata = {12'h0, sync_chk_ff, preop_ff, dc_en_ff, wdg_en_ff,
                                   wdg_cnt_ff};
      fcc_pkg::OFF_FAULT: hrdata = {23'h0, fault_ff};
      fcc_pkg::OFF_CODE: hrdata = {16'h0, display_code};
      fcc_pkg::OFF_MAP_IDX: hrdata = map_idx_ff;
      default: hrdata = 32'h0000_0000;
    endcase
  end

  a_wdg_fault_set: assert property (@(posedge hclk) disable iff (!hresetn) // [R15]
    chk_pulse && wdg_en_ff && wdg_cnt_ff == 16'h0000 |=> fault_ff[fcc_pkg::F_WDG])
    else $error("watchdog fault not latched");
  a_wdg_off_cnt: assert property (@(posedge hclk) disable iff (!hresetn) // [R15]
    chk_pulse && !wdg_en_ff && wdg_cnt_ff != 16'h0000 |=> fault_ff[fcc_pkg::F_WDG])
    else $error("disabled watchdog count missed");
  a_esi_fault_set: assert property (@(posedge hclk) disable iff (!hresetn) // [R17]
    esi_load_fail [*3] |=> fault_ff[fcc_pkg::F_ESI])
    else $error("description fault not latched");
  a_eep_fault_set: assert property (@(posedge hclk) disable iff (!hresetn) // [R18]
    eep_read_fail [*3] |=> fault_ff[fcc_pkg::F_EEP])
    else $error("eeprom fault not latched");
  a_model_fault_set: assert property (@(posedge hclk) disable iff (!hresetn) // [R19]
    model_mismatch [*3] |=> fault_ff[fcc_pkg::F_MODEL])
    else $error("model fault not latched");
  a_sync_lock: assert property (@(posedge hclk) disable iff (!hresetn) // [R16]
    (sync_chk_ff && dc_en_ff && !dc_running) [*3] |=> fault_ff[fcc_pkg::F_SYNC])
    else $error("sync fault missed");

  // Mapping and mailbox checks
  a_map_over: assert property (@(posedge hclk) disable iff (!hresetn) // [R1]
    chk_pulse && map_cnt_ff[4:0] > fcc_pkg::MAX_MAP |=> fault_ff[fcc_pkg::F_MAP])
    else $error("mapping overflow missed");
  a_tx_map_over: assert property (@(posedge hclk) disable iff (!hresetn) // [R1]
    chk_pulse && map_cnt_ff[9:5] > fcc_pkg::MAX_MAP |=> fault_ff[fcc_pkg::F_MAP])
    else $error("transmit mapping overflow missed");
  a_mbx_zero_len: assert property (@(posedge hclk) disable iff (!hresetn) // [R2]
    chk_pulse && mbx_out_ff.len == 14'h0000 |=> fault_ff[fcc_pkg::F_MBX])
    else $error("mailbox fault missed");

  // Output channel checks
  a_rx_idx_high: assert property (@(posedge hclk) disable iff (!hresetn) // [R3]
    chk_pulse && map_cnt_ff[4:0] != 5'h00 && map_idx_ff[15:0] > fcc_pkg::RX_IDX_HI
    |=> fault_ff[fcc_pkg::F_OUT]) else $error("receive index fault missed");
  a_rx_idx_low: assert property (@(posedge hclk) disable iff (!hresetn) // [R3]
    chk_pulse && map_cnt_ff[4:0] != 5'h00 && map_idx_ff[15:0] < fcc_pkg::RX_IDX_LO
    |=> fault_ff[fcc_pkg::F_OUT]) else $error("receive index fault missed");
  a_out_off_len: assert property (@(posedge hclk) disable iff (!hresetn) // [R4]
    chk_pulse && !out_ch_ff.en && rx_len_ff != 16'h0000 |=> fault_ff[fcc_pkg::F_OUT])
    else $error("disabled output length missed");
  a_rx_len_match: assert property (@(posedge hclk) disable iff (!hresetn) // [R5]
    chk_pulse && out_ch_ff.en && rx_len_ff != exp_rx_len_ff |=> fault_ff[fcc_pkg::F_OUT])
    else $error("receive length mismatch missed");
  a_out_dir: assert property (@(posedge hclk) disable iff (!hresetn) // [R6]
    chk_pulse && out_ch_ff.en && !out_ch_ff.dir_write |=> fault_ff[fcc_pkg::F_OUT])
    else $error("output direction fault missed");
  a_rx_addr_clash: assert property (@(posedge hclk) disable iff (!hresetn) // [R7]
    chk_pulse && out_ch_ff.en && !preop_ff && out_ch_ff.start == rx_addr_ff
    |=> fault_ff[fcc_pkg::F_OUT]) else $error("receive start clash missed");
  a_out_overlap: assert property (@(posedge hclk) disable iff (!hresetn) // [R8]
    chk_pulse && ovl(out_ch_ff, in_ch_ff) |=> fault_ff[fcc_pkg::F_OUT])
    else $error("output overlap missed");

  // Input channel checks
  a_tx_idx_low: assert property (@(posedge hclk) disable iff (!hresetn) // [R9]
    chk_pulse && map_cnt_ff[9:5] != 5'h00 && map_idx_ff[31:16] < fcc_pkg::TX_IDX_LO
    |=> fault_ff[fcc_pkg::F_IN]) else $error("transmit index fault missed");
  a_in_off_len: assert property (@(posedge hclk) disable iff (!hresetn) // [R10]
    chk_pulse && !in_ch_ff.en && tx_len_ff != 16'h0000 |=> fault_ff[fcc_pkg::F_IN])
    else $error("disabled input length missed");
  a_tx_len_match: assert property (@(posedge hclk) disable iff (!hresetn) // [R11]
    chk_pulse && in_ch_ff.en && tx_len_ff != exp_tx_len_ff |=> fault_ff[fcc_pkg::F_IN])
    else $error("transmit length mismatch missed");
  a_in_dir: assert property (@(posedge hclk) disable iff (!hresetn) // [R12]
    chk_pulse && in_ch_ff.en && in_ch_ff.dir_write |=> fault_ff[fcc_pkg::F_IN])
    else $error("input direction fault missed");
  a_tx_addr_win: assert property (@(posedge hclk) disable iff (!hresetn) // [R13]
    chk_pulse && in_ch_ff.en && preop_ff && tx_addr_ff > tx_win_ff.hi
    |=> fault_ff[fcc_pkg::F_IN]) else $error("transmit window fault missed");
  a_tx_addr_low: assert property (@(posedge hclk) disable iff (!hresetn) // [R13]
    chk_pulse && in_ch_ff.en && preop_ff && tx_addr_ff < tx_win_ff.lo
    |=> fault_ff[fcc_pkg::F_IN]) else $error("transmit window fault missed");
  a_tx_addr_clash: assert property (@(posedge hclk) disable iff (!hresetn) // [R13]
    chk_pulse && in_ch_ff.en && !preop_ff && in_ch_ff.start == tx_addr_ff
    |=> fault_ff[fcc_pkg::F_IN]) else $error("transmit start clash missed");
  a_in_overlap: assert property (@(posedge hclk) disable iff (!hresetn) // [R14]
    chk_pulse && ovl(out_ch_ff, mbx_in_ff) |=> fault_ff[fcc_pkg::F_IN])
    else $error("buffer limit fault missed");

  // Latch and display behaviour
  a_fault_held: assert property (@(posedge hclk) disable iff (!hresetn) // [R21]
    fault_ff[fcc_pkg::F_MAP] && !(wr_ff && addr_ff == fcc_pkg::OFF_FAULT)
    |=> fault_ff[fcc_pkg::F_MAP])
    else $error("fault dropped without clear");
  a_cfg_stable: assert property (@(posedge hclk) disable iff (!hresetn) // [R21]
    !chk_pulse && !(wr_ff && addr_ff == fcc_pkg::OFF_FAULT)
    |=> $stable(fault_ff[fcc_pkg::F_WDG:fcc_pkg::F_MAP]))
    else $error("configuration fault changed without cause");
  a_fault_clear: assert property (@(posedge hclk) disable iff (!hresetn) // [R21]
    wr_ff && addr_ff == fcc_pkg::OFF_FAULT && hwdata[fcc_pkg::F_MAP]
    |=> !fault_ff[fcc_pkg::F_MAP]) else $error("mapping fault not cleared");
  a_display_map: assert property (@(posedge hclk) disable iff (!hresetn) // [R20]
    fault_ff[fcc_pkg::F_MAP] |=> display_code == fcc_pkg::C_MAP)
    else $error("display code wrong");
  a_display_sync: assert property (@(posedge hclk) disable iff (!hresetn) // [R20]
    fault_ff[fcc_pkg::F_SYNC] && fault_ff[fcc_pkg::F_WDG:fcc_pkg::F_MAP] == 5'h00
    |=> display_code == fcc_pkg::C_SYNC) else $error("sync display code wrong");
  a_display_none: assert property (@(posedge hclk) disable iff (!hresetn) // [R20]
    fault_ff == '0 |=> display_code == fcc_pkg::C_NONE)
    else $error("display not blank");

endmodule
`default_nettype wire

// File: sim/fcc_ahb_master.sv
// AHB-Lite master model standing in for the network master
`timescale 1ns/1ps
`default_nettype none
module fcc_ahb_master (
  // Bus
  input wire logic hclk,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  output logic hsel,
  output logic [31:0] haddr,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [2:0] hsize,
  output logic [31:0] hwdata
);
  logic [31:0] rd_data;
  event rd_done;

  initial begin
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
  end

  // One single word transfer; hwdata toggles when not meaningful
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= fcc_pkg::HTRANS_NONSEQ;
    hwrite <= wr;
    hwdata <= ~hwdata;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wr ? d : ~hwdata;
    do @(posedge hclk); while (hready !== 1'b1);
    if (!wr) begin
      rd_data = hrdata;
      -> rd_done;
    end
  endtask
endmodule
`default_nettype wire

// File: sim/fcc_checker_bench.sv
// Self-checking bench for the configuration checker
`timescale 1ns/1ps
`default_nettype none
module fcc_checker_bench;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, dc_running;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans;
  logic [2:0] hsize, pins;
  logic [15:0] display_code, wdg;
  logic [31:0] exp_q [$];
  int errors = 0;
  int cmp_count = 0;
  // Mutation of the clean setup: offset, word, expected faults
  localparam logic [48:0] CASES [21] = '{
    {8'h00, 32'h0000004b, 9'h001},
    {8'h00, 32'h00000162, 9'h001},
    {8'h00, 32'h0000014a, 9'h000},
    {8'h14, 32'h10000000, 9'h002},
    {8'h30, 32'h1a00170b, 9'h004},
    {8'h30, 32'h1a00170a, 9'h000},
    {8'h04, 32'h00081100, 9'h004},
    {8'h18, 32'h00080004, 9'h004},
    {8'h04, 32'h80081100, 9'h004},
    {8'h08, 32'h00080fff, 9'h004},
    {8'h04, 32'hc00810fc, 9'h00c},
    {8'h30, 32'h1b0b1600, 9'h008},
    {8'h30, 32'h19ff1600, 9'h008},
    {8'h0c, 32'h00081200, 9'h008},
    {8'h18, 32'h00040008, 9'h008},
    {8'h0c, 32'hc0081200, 9'h008},
    {8'h10, 32'h00082000, 9'h008},
    {8'h04, 32'hc00811fc, 9'h00c},
    {8'h20, 32'h00050000, 9'h010},
    {8'h20, 32'h00040123, 9'h010},
    {8'h20, 32'h00010064, 9'h00c}
  };
  localparam logic [2:0] PINS [4] = '{3'h1, 3'h2, 3'h4, 3'h6};

  fcc_checker #(.MAP_MAX(10)) fcc_checker_i (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .esi_load_fail(pins[0]), .eep_read_fail(pins[1]), .model_mismatch(pins[2]),
    .dc_running(dc_running), .display_code(display_code)
  );

  fcc_ahb_master fcc_ahb_master_i (
    .hclk(hclk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata)
  );

  always #25 hclk = ~hclk;

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Read results are compared as they come off the bus
  always @(fcc_ahb_master_i.rd_done) begin
    chk("hrdata", fcc_ahb_master_i.rd_data, exp_q.pop_front());
  end

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    fcc_ahb_master_i.xfer(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    fcc_ahb_master_i.xfer(1'b0, a, 32'h0);
  endtask

  function automatic logic [31:0] code_of(input logic [8:0] f);
    logic [15:0] c [9];
    c = '{fcc_pkg::C_MAP, fcc_pkg::C_MBX, fcc_pkg::C_OUT, fcc_pkg::C_IN, fcc_pkg::C_WDG,
      fcc_pkg::C_SYNC, fcc_pkg::C_ESI, fcc_pkg::C_EEP, fcc_pkg::C_MODEL};
    code_of = 32'(fcc_pkg::C_NONE);
    for (int k = 8; k >= 0; k--) begin
      if (f[k]) code_of = 32'(c[k]);
    end
  endfunction

  // Clean setup with both mailboxes sized properly
  task automatic load_base();
    wr(fcc_pkg::OFF_MAP_CNT, 32'h00000042);
    wr(fcc_pkg::OFF_OUT_CH, 32'hc0081100);
    wr(fcc_pkg::OFF_OUT_ADDR, 32'h00081100);
    wr(fcc_pkg::OFF_IN_CH, 32'h80081200);
    wr(fcc_pkg::OFF_IN_ADDR, 32'h00081200);
    wr(fcc_pkg::OFF_MBX, 32'h10000080);
    wr(fcc_pkg::OFF_PDO_LEN, 32'h00080008);
    wr(fcc_pkg::OFF_WIN, 32'h10001fff);
    wr(fcc_pkg::OFF_MISC, {12'h000, 4'h5, wdg});
    wr(fcc_pkg::OFF_MAP_IDX, 32'h1a001600);
  endtask

  task automatic settle_fault(input logic [8:0] f);
    rd(fcc_pkg::OFF_CODE, code_of(f));
    chk("display_code", 32'(display_code), code_of(f));
    wr(fcc_pkg::OFF_FAULT, 32'h1ff);
    rd(fcc_pkg::OFF_FAULT, 32'h0);
  endtask

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge hclk);
    errors++;
    end_of_test();
  end

  initial begin
    hclk = 1'b0;
    hresetn = 1'b0;
    pins = 3'h0;
    dc_running = 1'b1;
    void'($urandom(14023));
    wdg = 16'($urandom_range(16'hffff, 1));
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    rd(fcc_pkg::OFF_FAULT, 32'h0);
    wr(8'h3c, 32'hffffffff);
    rd(8'h3c, 32'h0);
    chk("hresp", 32'(hresp), 32'h0);
    chk("hreadyout", 32'(hreadyout), 32'h1);
    settle_fault(9'h000);
    $display("reset test done");
    foreach (CASES[i]) begin
      load_base();
      wr(CASES[i][48:41], CASES[i][40:9]);
      wr(fcc_pkg::OFF_CHECK, 32'h1);
      rd(fcc_pkg::OFF_FAULT, 32'(CASES[i][8:0]));
      settle_fault(CASES[i][8:0]);
      $display("config case %0d done", i);
    end
    load_base();
    rd(fcc_pkg::OFF_WIN, 32'h10001fff);
    wr(fcc_pkg::OFF_MISC, {12'h000, 4'hb, wdg});
    dc_running <= 1'b0;
    repeat (6) @(posedge hclk);
    rd(fcc_pkg::OFF_FAULT, 32'h20);
    dc_running <= 1'b1;
    repeat (6) @(posedge hclk);
    settle_fault(9'h020);
    $display("sync test done");
    foreach (PINS[k]) begin
      pins <= PINS[k];
      repeat (6) @(posedge hclk);
      wr(fcc_pkg::OFF_FAULT, 32'h1ff);
      rd(fcc_pkg::OFF_FAULT, 32'({PINS[k], 6'h0}));
      pins <= 3'h0;
      repeat (6) @(posedge hclk);
      settle_fault({PINS[k], 6'h0});
      $display("pin case %0d done", k);
    end
    end_of_test();
  end
endmodule
`default_nettype wire
